/* bench/emr_host_model.sv */
// host side model: drives the serial port and returns each read word
`timescale 1ns/10ps
module emr_host_model
(
   input wire logic clock,
   output logic serialClk,
   output logic serialSelN,
   output logic serialIn,
   input wire logic serialOut,
   output logic [23:0] rdData,
   output logic rdValid
);
   // six clocks a half period leaves margin over the three-stage synchroniser
   localparam int HALF = 6;
   initial
   begin
      serialClk = 1'b1;
      serialSelN = 1'b1;
      serialIn = 1'b0;
      rdData = 24'h0;
      rdValid = 1'b0;
   end
   function automatic int reg_bits(input logic [5:0] a);
      if ((a >= 6'h01 && a <= 6'h06) || a == 6'h09)
         return 24;
      if (a == 6'h07 || (a >= 6'h0f && a <= 6'h11))
         return 16;
      return 8;
   endfunction
   task automatic access(input logic wr, input logic [5:0] addr, input logic [23:0] wdata);
      logic [7:0] cmd;
      logic [23:0] shiftQ;
      int n;
      cmd = {wr, 1'b0, addr};
      n = reg_bits(addr);
      shiftQ = 24'h0;
      @(posedge clock);
      serialSelN <= 1'b0;
      repeat (HALF) @(posedge clock);
      for (int i = n + 7; i >= 0; i--)
      begin
         serialIn <= (i >= n) ? cmd[i - n] : wdata[i];
         repeat (HALF) @(posedge clock);
         if (i < n)
            shiftQ = {shiftQ[22:0], serialOut};
         serialClk <= 1'b0;
         repeat (HALF) @(posedge clock);
         serialClk <= 1'b1;
      end
      repeat (HALF) @(posedge clock);
      serialSelN <= 1'b1;
      // a released data line flips so a stale level never passes for data
      serialIn <= ~serialIn;
      rdData <= shiftQ;
      rdValid <= ~wr;
      @(posedge clock);
      rdValid <= 1'b0;
   endtask
endmodule

/* bench/energy_meter_result_mode_regs_test.sv */
// self-checking bench for the energy meter result and mode register bank
`timescale 1ns/10ps
module energy_meter_result_mode_regs_test;
   logic clock, rst, serialClk, serialSelN, serialIn, serialOut, serialOutOe, irqOutN, irqOe;
   logic halfCycle, periodValid, tempValid, rdValid;
   logic [15:0] halfCycleCount, events;
   logic [2:0][14:0] phasePeriod;
   logic [7:0] tempIn;
   logic [23:0] rdData;
   emr_pkg::emr_power_t power;
   emr_pkg::emr_wave_t wave;
   emr_pkg::emr_config_t cfgOut;
   logic [23:0] expQ[$];
   int mismatches, total_checks, cycles, seed;
   localparam int LIMIT = 60000;
   emr_regs dut_u (.clock(clock), .rst(rst), .serialClk(serialClk), .serialSelN(serialSelN),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe), .irqOutN(irqOutN),
      .irqOe(irqOe), .power(power), .wave(wave), .halfCycle(halfCycle),
      .halfCycleCount(halfCycleCount), .phasePeriod(phasePeriod), .periodValid(periodValid),
      .tempIn(tempIn), .tempValid(tempValid), .events(events), .modeConfig(cfgOut));
   emr_host_model host_u (.clock(clock), .serialClk(serialClk), .serialSelN(serialSelN),
      .serialIn(serialIn), .serialOut(serialOut), .rdData(rdData), .rdValid(rdValid));
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ----------------------------------------
   // checking and reporting
   // ----------------------------------------
   task automatic complete_run();
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         complete_run();
      end
   end
   // results are matched oldest first against what the driver queued
   always @(posedge clock)
   begin
      if (rdValid && expQ.size() == 0)
         check("read count", 24'h1, 24'h0);
      else if (rdValid)
         check("read data", rdData, expQ.pop_front());
   end
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   task automatic expect_read(input logic [5:0] a, input logic [23:0] e);
      expQ.push_back(e);
      host_u.access(1'b0, a, 24'h0);
   endtask
   task automatic pulse_event(input logic [15:0] e);
      @(posedge clock);
      events <= e;
      @(posedge clock);
      events <= 16'h0;
   endtask
   function automatic logic [23:0] reset_val(input logic [5:0] a);
      case (a)
         6'h0a: return 24'h04;
         6'h0b: return 24'h70;
         6'h0d, 6'h0e: return 24'h3f;
         default: return 24'h0;
      endcase
   endfunction
   initial
   begin
      logic [23:0] d;
      rst = 1'b1;
      power = '0;
      wave = '0;
      halfCycle = 1'b0;
      halfCycleCount = 16'h0002;
      phasePeriod = '0;
      periodValid = 1'b0;
      tempIn = 8'h00;
      tempValid = 1'b0;
      events = 16'h0;
      seed = $urandom(89);
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("config", {cfgOut.operating, cfgOut.measurement, cfgOut.apparentFormula}, 24'h04703f);
      for (int a = 0; a <= 18; a++)
         expect_read(a[5:0], reset_val(a[5:0]));
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clock);
         power.active <= {3{16'h4000}};
         power.apparent <= {3{16'h2000}};
         power.valid <= 1'b1;
         halfCycle <= k[0];
         @(posedge clock);
         power.valid <= 1'b0;
         halfCycle <= 1'b0;
      end
      // visible bits sit sixteen above the accumulator's lsb
      for (int e = 0; e < 2; e++)
      begin
         d = (e == 0) ? 24'h6 : 24'h3;
         expect_read(6'h01 + 6'(3 * e), d);
         expect_read(6'h01 + 6'(3 * e), d);
         expect_read(6'h02 + 6'(3 * e), d);
         expect_read(6'h01 + 6'(3 * e), 24'h0);
      end
      // the first line period after reset is partial; the second sums four samples
      expect_read(6'h03, 24'h000003);
      expect_read(6'h06, 24'h000001);
      for (int a = 10; a <= 15; a++)
      begin
         d = 24'($urandom());
         host_u.access(1'b1, a[5:0], d);
         expect_read(a[5:0], (a == 15) ? {8'h0, d[15:0]} : {16'h0, d[7:0]});
      end
      // abs mode, phases a and c only: a negative phase c term still adds
      host_u.access(1'b1, 6'h0d, 24'h000068);
      repeat (2)
      begin
         @(posedge clock);
         power.active <= {16'hc000, 16'h4000, 16'h4000};
         power.valid <= 1'b1;
         @(posedge clock);
         power.valid <= 1'b0;
      end
      expect_read(6'h02, 24'h000001);
      host_u.access(1'b1, 6'h08, 24'h0000a5);
      host_u.access(1'b1, 6'h00, 24'h0000ff);
      expect_read(6'h08, 24'h0);
      expect_read(6'h00, 24'h0);
      for (int t = 0; t < 2; t++)
      begin
         @(posedge clock);
         tempIn <= 8'($urandom());
         tempValid <= 1'b1;
         @(posedge clock);
         tempValid <= 1'b0;
         expect_read(6'h08, {16'h0, tempIn});
      end
      host_u.access(1'b1, 6'h0b, 24'h71);
      @(posedge clock);
      phasePeriod <= {15'($urandom()), 15'($urandom()), 15'($urandom())};
      periodValid <= 1'b1;
      @(posedge clock);
      periodValid <= 1'b0;
      expect_read(6'h07, {9'h0, phasePeriod[1]});
      for (int k = 0; k < 6; k++)
      begin
         host_u.access(1'b1, 6'h0c, 24'(k));
         @(posedge clock);
         for (int s = 0; s < 6; s++)
            wave.sample[s] <= 24'($urandom());
         wave.valid <= 1'b1;
         @(posedge clock);
         wave.valid <= 1'b0;
         expect_read(6'h09, wave.sample[k]);
      end
      host_u.access(1'b1, 6'h0f, 24'h0);
      pulse_event(16'h0008);
      repeat (4) @(posedge clock);
      check("irq", {23'h0, irqOe}, 24'h0);
      expect_read(6'h10, 24'h0008);
      host_u.access(1'b1, 6'h0f, 24'hffff);
      repeat (4) @(posedge clock);
      check("irq", {23'h0, irqOe}, 24'h1);
      check("irq pin", {23'h0, irqOutN}, 24'h0);
      // an event landing in the data phase must survive the clear
      fork
         expect_read(6'h11, 24'h0008);
         begin
            repeat (160) @(posedge clock);
            pulse_event(16'h0020);
            repeat (10) @(posedge clock);
            check("irq", {23'h0, irqOe}, 24'h0);
         end
      join
      repeat (4) @(posedge clock);
      check("irq", {23'h0, irqOe}, 24'h1);
      expect_read(6'h10, 24'h0020);
      expect_read(6'h11, 24'h0020);
      pulse_event(16'h0100);
      repeat (4) @(posedge clock);
      check("irq", {23'h0, irqOe}, 24'h1);
      expect_read(6'h11, 24'h0100);
      expect_read(6'h10, 24'h0);
      repeat (4) @(posedge clock);
      check("irq", {23'h0, irqOe}, 24'h0);
      complete_run();
   end
endmodule

/* rtl/emr_regs.sv */
// energy meter result and mode register bank behind the serial port
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
module emr_regs
(
   input wire logic clock,
   input wire logic rst,
   input wire logic serialClk,
   input wire logic serialSelN,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutOe,
   output logic irqOutN,
   output logic irqOe,
   input wire emr_pkg::emr_power_t power,
   input wire emr_pkg::emr_wave_t wave,
   input wire logic halfCycle,
   input wire logic [15:0] halfCycleCount,
   input wire logic [2:0][14:0] phasePeriod,
   input wire logic periodValid,
   input wire logic [7:0] tempIn,
   input wire logic tempValid,
   input wire logic [15:0] events,
   output emr_pkg::emr_config_t modeConfig
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic sclkS1, sclkS2, sclkS3, selS1, selS2, dinS1, dinS2;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sclkS1 <= 1'b1;
         sclkS2 <= 1'b1;
         sclkS3 <= 1'b1;
         selS1 <= 1'b1;
         selS2 <= 1'b1;
         dinS1 <= 1'b0;
         dinS2 <= 1'b0;
      end
      else
      begin
         sclkS1 <= serialClk;
         sclkS2 <= sclkS1;
         sclkS3 <= sclkS2;
         selS1 <= serialSelN;
         selS2 <= selS1;
         dinS1 <= serialIn;
         dinS2 <= dinS1;
      end
   end
   logic active, sclkRise, sclkFall;
   assign active = ~selS2;
   assign sclkRise = sclkS2 & ~sclkS3;
   assign sclkFall = ~sclkS2 & sclkS3;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [emr_pkg::ACC_W-1:0] actAcc_q, appAcc_q, lineActWork_q, lineAppWork_q;
   logic [emr_pkg::ENERGY_W-1:0] lineAct_q, lineApp_q, wave_q;
   logic [emr_pkg::PERIOD_W-1:0] period_q;
   logic [emr_pkg::TEMP_W-1:0] temp_q;
   logic [15:0] halfCnt_q, mask_q;
   logic [emr_pkg::FLAG_W-1:0] flags_q;
   logic [7:0] opCfg_q, measCfg_q, wavCfg_q, actForm_q, appForm_q;
   emr_pkg::emr_spi_state_t state_q;
   logic [4:0] bitCnt_q;
   logic [5:0] addr_q;
   logic [23:0] rxShift_q, txShift_q;
   logic irqBlock_q;

   // ----------------------------------------
   // power combination
   // ----------------------------------------
   function automatic logic [emr_pkg::ACC_W-1:0] combine(input logic [2:0][15:0] t,
      input logic [2:0] en, input logic [1:0] mode);
      logic signed [19:0] sum;
      logic signed [19:0] term;
      sum = '0;
      for (int i = 0; i < 3; i++)
      begin
         term = 20'(signed'(t[i]));
         if (mode == emr_pkg::FMODE_ABS && term < 0)
            term = -term;
         if (mode[1] && i == 1)
            term = -term;
         if (en[i])
            sum = sum + term;
      end
      return {{(emr_pkg::ACC_W-20){sum[19]}}, sum};
   endfunction

   logic [emr_pkg::ACC_W-1:0] actInc, appInc, lineActInc, lineAppInc;
   always_comb
   begin
      actInc = '0;
      appInc = '0;
      lineActInc = '0;
      lineAppInc = '0;
      if (power.valid)
      begin
         actInc = combine(power.active, actForm_q[emr_pkg::FORM_ACC_LSB +: 3],
            actForm_q[emr_pkg::FORM_MODE_LSB +: 2]);
         appInc = combine(power.apparent, appForm_q[emr_pkg::FORM_ACC_LSB +: 3],
            appForm_q[emr_pkg::FORM_MODE_LSB +: 2]);
         lineActInc = combine(power.active, actForm_q[emr_pkg::FORM_LINE_LSB +: 3], 2'h0);
         lineAppInc = combine(power.apparent, appForm_q[emr_pkg::FORM_LINE_LSB +: 3], 2'h0);
      end
   end

   // ----------------------------------------
   // serial command decode
   // ----------------------------------------
   logic cmdDone, readCapture, wrStrobe, readEnd;
   logic [5:0] capAddr;
   logic [23:0] wrData;
   logic [4:0] dataBits;
   assign cmdDone = active & sclkFall & (state_q == emr_pkg::SP_CMD) &
      (bitCnt_q == emr_pkg::CMD_LAST_BIT);
   assign capAddr = {rxShift_q[4:0], dinS2};
   assign readCapture = cmdDone & ~rxShift_q[emr_pkg::CMD_WRITE_BIT-1];
   assign wrData = {rxShift_q[22:0], dinS2};
   assign wrStrobe = active & sclkFall & (state_q == emr_pkg::SP_WRITE) &
      (bitCnt_q == dataBits - 5'h01);
   assign readEnd = active & sclkFall & (state_q == emr_pkg::SP_READ) &
      (bitCnt_q == dataBits - 5'h01);

   function automatic logic [4:0] widthOf(input logic [5:0] a);
      if (a >= emr_pkg::ADDR_ACT_ACC && a <= emr_pkg::ADDR_LINE_APP || a == emr_pkg::ADDR_WAVE)
         return 5'h18;
      if (a == emr_pkg::ADDR_PERIOD || a >= emr_pkg::ADDR_MASK && a <= emr_pkg::ADDR_STATUS_RC)
         return 5'h10;
      return 5'h08;
   endfunction
   assign dataBits = widthOf(addr_q);

   // left aligned so the top bit leaves first
   logic [23:0] readWord;
   always_comb
   begin
      unique case (capAddr)
         emr_pkg::ADDR_ACT_ACC, emr_pkg::ADDR_ACT_RC:
            readWord = actAcc_q[emr_pkg::ACC_FRAC +: emr_pkg::ENERGY_W];
         emr_pkg::ADDR_LINE_ACT: readWord = lineAct_q;
         emr_pkg::ADDR_APP_ACC, emr_pkg::ADDR_APP_RC:
            readWord = appAcc_q[emr_pkg::ACC_FRAC +: emr_pkg::ENERGY_W];
         emr_pkg::ADDR_LINE_APP: readWord = lineApp_q;
         emr_pkg::ADDR_PERIOD: readWord = {1'b0, period_q, 8'h00};
         emr_pkg::ADDR_TEMP: readWord = {temp_q, 16'h0000};
         emr_pkg::ADDR_WAVE: readWord = wave_q;
         emr_pkg::ADDR_OPCFG: readWord = {opCfg_q, 16'h0000};
         emr_pkg::ADDR_MEASCFG: readWord = {measCfg_q, 16'h0000};
         emr_pkg::ADDR_WAVCFG: readWord = {wavCfg_q, 16'h0000};
         emr_pkg::ADDR_ACTFORM: readWord = {actForm_q, 16'h0000};
         emr_pkg::ADDR_APPFORM: readWord = {appForm_q, 16'h0000};
         emr_pkg::ADDR_MASK: readWord = {mask_q, 8'h00};
         emr_pkg::ADDR_FLAGS, emr_pkg::ADDR_STATUS_RC: readWord = {flags_q, 8'h00};
         default: readWord = 24'h000000;
      endcase
   end

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= emr_pkg::SP_CMD;
         bitCnt_q <= 5'h00;
         addr_q <= 6'h00;
         rxShift_q <= 24'h000000;
      end
      else if (!active)
      begin
         state_q <= emr_pkg::SP_CMD;
         bitCnt_q <= 5'h00;
      end
      else if (sclkFall)
      begin
         rxShift_q <= wrData;
         if (cmdDone)
         begin
            bitCnt_q <= 5'h00;
            addr_q <= capAddr;
            state_q <= readCapture ? emr_pkg::SP_READ : emr_pkg::SP_WRITE;
         end
         else if (wrStrobe || readEnd)
         begin
            bitCnt_q <= 5'h00;
            state_q <= emr_pkg::SP_CMD;
         end
         else
            bitCnt_q <= bitCnt_q + 5'h01;
      end
   end

   // whole word frozen at addressing; later updates cannot tear a multi-byte read
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         txShift_q <= 24'h000000;
         serialOut <= 1'b0;
      end
      else if (readCapture)
         txShift_q <= readWord;
      else if (active && sclkRise && state_q == emr_pkg::SP_READ)
      begin
         serialOut <= txShift_q[23];
         txShift_q <= {txShift_q[22:0], 1'b0};
      end
   end
   assign serialOutOe = active & (state_q == emr_pkg::SP_READ);

   // ----------------------------------------
   // writable configuration
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         opCfg_q <= emr_pkg::OPCFG_RST;
         measCfg_q <= emr_pkg::MEASCFG_RST;
         wavCfg_q <= emr_pkg::WAVCFG_RST;
         actForm_q <= emr_pkg::FORMULA_RST;
         appForm_q <= emr_pkg::FORMULA_RST;
         mask_q <= emr_pkg::MASK_RST;
      end
      else if (wrStrobe)
      begin
         unique case (addr_q)
            emr_pkg::ADDR_OPCFG: opCfg_q <= wrData[7:0];
            emr_pkg::ADDR_MEASCFG: measCfg_q <= wrData[7:0];
            emr_pkg::ADDR_WAVCFG: wavCfg_q <= wrData[7:0];
            emr_pkg::ADDR_ACTFORM: actForm_q <= wrData[7:0];
            emr_pkg::ADDR_APPFORM: appForm_q <= wrData[7:0];
            emr_pkg::ADDR_MASK: mask_q <= wrData[15:0];
            default: ;
         endcase
      end
   end
   assign modeConfig = '{operating: opCfg_q, measurement: measCfg_q, waveform: wavCfg_q,
      activeFormula: actForm_q, apparentFormula: appForm_q};

   // ----------------------------------------
   // energy accumulators
   // ----------------------------------------
   logic clrAct, clrApp;
   assign clrAct = readCapture & (capAddr == emr_pkg::ADDR_ACT_RC);
   assign clrApp = readCapture & (capAddr == emr_pkg::ADDR_APP_RC);

   // 16 guard bits below the visible word give the 88 s headroom
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         actAcc_q <= '0;
         appAcc_q <= '0;
      end
      else
      begin
         actAcc_q <= (clrAct ? '0 : actAcc_q) + actInc;
         appAcc_q <= (clrApp ? '0 : appAcc_q) + appInc;
      end
   end

   // ----------------------------------------
   // line cycle accumulation
   // ----------------------------------------
   logic lineDone;
   assign lineDone = halfCycle & (halfCnt_q + 16'h0001 >= halfCycleCount);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         halfCnt_q <= 16'h0000;
         lineActWork_q <= '0;
         lineAppWork_q <= '0;
         lineAct_q <= '0;
         lineApp_q <= '0;
      end
      else
      begin
         if (lineDone)
         begin
            halfCnt_q <= 16'h0000;
            lineAct_q <= lineActWork_q[emr_pkg::ACC_FRAC +: emr_pkg::ENERGY_W];
            lineApp_q <= lineAppWork_q[emr_pkg::ACC_FRAC +: emr_pkg::ENERGY_W];
            lineActWork_q <= lineActInc;
            lineAppWork_q <= lineAppInc;
         end
         else
         begin
            if (halfCycle)
               halfCnt_q <= halfCnt_q + 16'h0001;
            lineActWork_q <= lineActWork_q + lineActInc;
            lineAppWork_q <= lineAppWork_q + lineAppInc;
         end
      end
   end

   // ----------------------------------------
   // period, temperature, waveform results
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         period_q <= '0;
         temp_q <= '0;
         wave_q <= '0;
      end
      else
      begin
         if (periodValid && measCfg_q[1:0] != 2'h3)
            period_q <= phasePeriod[measCfg_q[1:0]];
         if (tempValid)
            temp_q <= tempIn;
         if (wave.valid && wavCfg_q[2:0] < 3'h6)
            wave_q <= wave.sample[wavCfg_q[2:0]];
      end
   end

   // ----------------------------------------
   // interrupt flags and request
   // ----------------------------------------
   logic statusCapture;
   assign statusCapture = readCapture & (capAddr == emr_pkg::ADDR_STATUS_RC);
   // cleared at capture, not at the end, so events during the transfer stay pending
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         flags_q <= '0;
      else
         flags_q <= (statusCapture ? '0 : flags_q) | events;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         irqBlock_q <= 1'b0;
      else if (statusCapture)
         irqBlock_q <= 1'b1;
      else if (readEnd || !active)
         irqBlock_q <= 1'b0;
   end
   assign irqOutN = 1'b0;
   assign irqOe = (|(flags_q & mask_q)) & ~irqBlock_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence sStatusRead;
      statusCapture;
   endsequence
   sequence sBlocked;
      !irqOe [*2];
   endsequence

   a_irq_mask_gate: assert property ((|(events & mask_q)) && !irqBlock_q && !statusCapture && !wrStrobe |=> irqOe)
      else $error("masked-in flag does not pull request low");
   a_irq_read_hold: assert property (sStatusRead |=> sBlocked)
      else $error("request active during status read-clear");
   a_flag_set_always: assert property (|events |=> (flags_q & $past(events)) == $past(events))
      else $error("event flag not set");
   a_status_clear_keep: assert property (sStatusRead |=> flags_q == $past(events))
      else $error("status read-clear lost or kept flags");
   a_active_rc_restart: assert property (clrAct |=> actAcc_q == $past(actInc))
      else $error("active read-clear did not restart accumulator");
   a_active_plain_keep: assert property (readCapture && capAddr == emr_pkg::ADDR_ACT_ACC
      |=> actAcc_q == $past(actAcc_q) + $past(actInc))
      else $error("plain active read disturbed accumulator");
   a_temp_latest: assert property (tempValid |=> temp_q == $past(tempIn))
      else $error("temperature not latest");
   a_capture_word: assert property (readCapture |=> txShift_q == $past(readWord))
      else $error("read word not captured");
   a_reset_values: assert property (disable iff (1'b0) $fell(rst) |-> opCfg_q == 8'h04
      && measCfg_q == 8'h70 && actForm_q == 8'h3f && appForm_q == 8'h3f)
      else $error("wrong reset values");
endmodule

/* shared/emr_pkg.sv */
// package: register map, reset values and carriers for the energy meter result/mode bank
package emr_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [5:0] ADDR_RESERVED = 6'h00;
   localparam logic [5:0] ADDR_ACT_ACC = 6'h01;
   localparam logic [5:0] ADDR_ACT_RC = 6'h02;
   localparam logic [5:0] ADDR_LINE_ACT = 6'h03;
   localparam logic [5:0] ADDR_APP_ACC = 6'h04;
   localparam logic [5:0] ADDR_APP_RC = 6'h05;
   localparam logic [5:0] ADDR_LINE_APP = 6'h06;
   localparam logic [5:0] ADDR_PERIOD = 6'h07;
   localparam logic [5:0] ADDR_TEMP = 6'h08;
   localparam logic [5:0] ADDR_WAVE = 6'h09;
   localparam logic [5:0] ADDR_OPCFG = 6'h0a;
   localparam logic [5:0] ADDR_MEASCFG = 6'h0b;
   localparam logic [5:0] ADDR_WAVCFG = 6'h0c;
   localparam logic [5:0] ADDR_ACTFORM = 6'h0d;
   localparam logic [5:0] ADDR_APPFORM = 6'h0e;
   localparam logic [5:0] ADDR_MASK = 6'h0f;
   localparam logic [5:0] ADDR_FLAGS = 6'h10;
   localparam logic [5:0] ADDR_STATUS_RC = 6'h11;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] OPCFG_RST = 8'h04;
   localparam logic [7:0] MEASCFG_RST = 8'h70;
   localparam logic [7:0] WAVCFG_RST = 8'h00;
   localparam logic [7:0] FORMULA_RST = 8'h3f;
   localparam logic [15:0] MASK_RST = 16'h0000;
   // ----------------------------------------
   // field positions and widths
   // ----------------------------------------
   localparam int CMD_WRITE_BIT = 7;
   localparam int FORM_LINE_LSB = 0;
   localparam int FORM_ACC_LSB = 3;
   localparam int FORM_MODE_LSB = 6;
   localparam logic [1:0] FMODE_ABS = 2'h1;
   localparam int ENERGY_W = 24;
   localparam int ACC_W = 40;
   localparam int ACC_FRAC = 16;
   localparam int PERIOD_W = 15;
   localparam int TEMP_W = 8;
   localparam int FLAG_W = 16;
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;
   // ----------------------------------------
   // overflow headroom: 40-bit accumulator, 24 visible bits
   // ----------------------------------------
   localparam longint HOLD_MIN_S = 88;
   localparam longint TERM_FULL_SCALE = 3 * 32768;
   localparam longint MAX_SAMPLE_HZ = (64'd1 << ACC_W) / (TERM_FULL_SCALE * HOLD_MIN_S);
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [2:0][15:0] active;
      logic [2:0][15:0] apparent;
      logic valid;
   } emr_power_t;
   typedef struct packed {
      logic [5:0][23:0] sample;
      logic valid;
   } emr_wave_t;
   typedef struct packed {
      logic [7:0] operating;
      logic [7:0] measurement;
      logic [7:0] waveform;
      logic [7:0] activeFormula;
      logic [7:0] apparentFormula;
   } emr_config_t;
   typedef enum logic [1:0] {
      SP_CMD = 2'b00,
      SP_READ = 2'b01,
      SP_WRITE = 2'b10
   } emr_spi_state_t;
endpackage
